// >>> hdl/pdm_ctrl.sv
// power-down mode controller: register, mode machine, clock and port control
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module pdm_ctrl #(
  parameter int RAM_KBYTES = pdm_pkg::PDM_RAM_KBYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [27:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire pdm_pkg::pdm_wake_t wake_in,
  input wire logic watchdog_run_enable,
  input wire logic watchdog_overflow,
  input wire logic nmi_edge_select,
  input wire logic nmi_pin,
  input wire logic reset_pin_n,
  output pdm_pkg::pdm_clk_t clk_ctrl,
  output pdm_pkg::pdm_exit_t exit_evt,
  output pdm_pkg::pdm_state_t mode,
  output logic port_hold,
  output logic port_float,
  input wire logic [27:0] mem_addr,
  output logic ram_sel,
  output logic ram_top_hit,
  output logic [$clog2(RAM_KBYTES*1024)-1:0] ram_offset
);
  import pdm_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic deep_mode_select_reg;
  logic deep_mode_select_next;
  logic port_float_select_reg;
  logic port_float_select_next;
  logic [7:0] standby_control_reg;
  logic reg_hit;
  logic wr_access;
  logic nmi_event;
  logic reset_fall;
  logic reset_is_por;
  logic irq_accepted;
  logic sleep_wake;
  pdm_state_t state_reg;
  pdm_state_t state_next;
  pdm_exit_t exit_next;
  pdm_clk_t clk_next;
  logic port_hold_next;
  logic port_float_next;

  // ------------------------------------------------------------
  // pin edge detection
  // ------------------------------------------------------------
  pdm_pin_detect u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .nmi_pin(nmi_pin),
    .reset_pin_n(reset_pin_n),
    .nmi_edge_select(nmi_edge_select),
    .nmi_event(nmi_event),
    .reset_fall(reset_fall),
    .reset_is_por(reset_is_por)
  );

  // ------------------------------------------------------------
  // ram address decode
  // ------------------------------------------------------------
  pdm_ram_decode #(
    .RAM_KBYTES(RAM_KBYTES)
  ) u_ram (
    .bus_addr(mem_addr),
    .ram_sel(ram_sel),
    .ram_top_hit(ram_top_hit),
    .ram_offset(ram_offset)
  );

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign reg_hit = (paddr == PDM_STBY_CTRL_ADDR);
  assign wr_access = psel & penable & pwrite & reg_hit;

  assign standby_control_reg = {deep_mode_select_reg, port_float_select_reg,
                                1'b0, PDM_ONES_FIELD};

  always_comb begin
    pslverr = psel & penable & ~reg_hit;
    prdata = 32'h0000_0000;
    if (psel && reg_hit && !pwrite) begin
      prdata = {24'h00_0000, standby_control_reg};
    end
  end

  // ------------------------------------------------------------
  // standby control register
  // ------------------------------------------------------------
  // setting either bit is refused while the watchdog is armed;
  // clearing is always allowed so software can back out
  always_comb begin
    deep_mode_select_next = deep_mode_select_reg;
    port_float_select_next = port_float_select_reg;
    if (wr_access) begin
      deep_mode_select_next = pwdata[PDM_DEEP_SEL_BIT] & ~watchdog_run_enable;
      port_float_select_next = pwdata[PDM_FLOAT_SEL_BIT] & ~watchdog_run_enable;
    end
    if (reset_fall) begin
      deep_mode_select_next = PDM_STBY_CTRL_RESET[PDM_DEEP_SEL_BIT];
      port_float_select_next = PDM_STBY_CTRL_RESET[PDM_FLOAT_SEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_mode_select_reg <= 1'b0;
      port_float_select_reg <= 1'b0;
    end else begin
      deep_mode_select_reg <= deep_mode_select_next;
      port_float_select_reg <= port_float_select_next;
    end
  end

  // ------------------------------------------------------------
  // wake qualification
  // ------------------------------------------------------------
  // an interrupt only counts if the cpu would actually take it
  assign irq_accepted = wake_in.irq_req
                      & wake_in.irq_periph_en
                      & (wake_in.irq_level > wake_in.cpu_mask);
  assign sleep_wake = irq_accepted | wake_in.dma_addr_err | nmi_event;

  // ------------------------------------------------------------
  // mode machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    exit_next = '0;
    case (state_reg)
      PDM_RUN: begin
        if (halt_exec) begin
          if (deep_mode_select_reg) begin
            state_next = PDM_STBY;
          end else begin
            state_next = PDM_SLEEP;
          end
        end
      end
      PDM_SLEEP: begin
        if (nmi_event) begin
          state_next = PDM_RUN;
          exit_next.nmi = 1'b1;
        end else if (irq_accepted) begin
          state_next = PDM_RUN;
          exit_next.irq = 1'b1;
        end else if (wake_in.dma_addr_err) begin
          state_next = PDM_RUN;
          exit_next.dma_err = 1'b1;
        end
      end
      PDM_STBY: begin
        // interrupts and dma errors cannot reach a stopped chip
        if (nmi_event) begin
          state_next = PDM_OSC_WAIT;
        end
      end
      PDM_OSC_WAIT: begin
        // watchdog overflow marks the oscillator as settled
        if (watchdog_overflow) begin
          state_next = PDM_RUN;
          exit_next.nmi = 1'b1;
        end
      end
      default: begin
        state_next = PDM_RUN;
      end
    endcase
    // the reset pin overrides every mode
    if (reset_fall) begin
      state_next = PDM_RUN;
      exit_next = '0;
      exit_next.power_on_reset = reset_is_por;
      exit_next.manual_reset = ~reset_is_por;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PDM_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_evt <= '0;
    end else begin
      exit_evt <= exit_next;
    end
  end

  assign mode = state_reg;

  // ------------------------------------------------------------
  // clock gating requests
  // ------------------------------------------------------------
  // the cpu is only stopped, never reset, so its registers survive
  always_comb begin
    clk_next = '1;
    case (state_next)
      PDM_RUN: begin
        clk_next = '1;
      end
      PDM_SLEEP: begin
        clk_next.cpu_run = 1'b0;
      end
      PDM_STBY: begin
        clk_next = '0;
      end
      PDM_OSC_WAIT: begin
        clk_next = '0;
        clk_next.wdt_clk_run = 1'b1;
      end
      default: begin
        clk_next = '1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl <= '1;
    end else begin
      clk_ctrl <= clk_next;
    end
  end

  // ------------------------------------------------------------
  // i/o port control
  // ------------------------------------------------------------
  // float only applies once the chip is really stopped
  always_comb begin
    port_hold_next = 1'b0;
    port_float_next = 1'b0;
    case (state_next)
      PDM_SLEEP: begin
        port_hold_next = 1'b1;
      end
      PDM_STBY, PDM_OSC_WAIT: begin
        port_hold_next = ~port_float_select_reg;
        port_float_next = port_float_select_reg;
      end
      default: begin
        port_hold_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_hold <= 1'b0;
      port_float <= 1'b0;
    end else begin
      port_hold <= port_hold_next;
      port_float <= port_float_next;
    end
  end

endmodule

// >>> shared/pdm_pkg.sv
// power-down mode controller: constants and types
package pdm_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [27:0] PDM_STBY_CTRL_ADDR = 28'h5ffffbc;
  localparam int PDM_DEEP_SEL_BIT = 7;
  localparam int PDM_FLOAT_SEL_BIT = 6;
  localparam int PDM_ZERO_BIT = 5;
  localparam logic [7:0] PDM_STBY_CTRL_RESET = 8'h1f;
  localparam logic [4:0] PDM_ONES_FIELD = 5'h1f;

  // ------------------------------------------------------------
  // on-chip ram map
  // ------------------------------------------------------------
  localparam logic [27:0] PDM_AREA7_BASE = 28'hf000000;
  localparam logic [3:0] PDM_AREA7_TAG = 4'hf;
  localparam logic [27:0] PDM_RAM8K_BASE = 28'hfffe000;
  localparam logic [27:0] PDM_RAM4K_BASE = 28'hffff000;
  localparam int PDM_RAM_KBYTES = 8;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    PDM_RUN = 4'b0001,
    PDM_SLEEP = 4'b0010,
    PDM_STBY = 4'b0100,
    PDM_OSC_WAIT = 4'b1000
  } pdm_state_t;

  typedef struct packed {
    logic irq_req;
    logic [3:0] irq_level;
    logic [3:0] cpu_mask;
    logic irq_periph_en;
    logic dma_addr_err;
  } pdm_wake_t;

  typedef struct packed {
    logic cpu_run;
    logic sys_clk_run;
    logic periph_clk_run;
    logic wdt_clk_run;
  } pdm_clk_t;

  typedef struct packed {
    logic irq;
    logic dma_err;
    logic nmi;
    logic power_on_reset;
    logic manual_reset;
  } pdm_exit_t;

endpackage

// >>> hdl/pdm_pin_detect.sv
// nmi edge and reset pin detection on the free-running clock
`timescale 1ns/1ps
module pdm_pin_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nmi_pin,
  input wire logic reset_pin_n,
  input wire logic nmi_edge_select,
  output logic nmi_event,
  output logic reset_fall,
  output logic reset_is_por
);
  logic nmi_prev_reg;
  logic rst_prev_reg;

  // ------------------------------------------------------------
  // previous pin levels
  // ------------------------------------------------------------
  // pclk never stops, only the gated clocks do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b1;
    end else begin
      nmi_prev_reg <= nmi_pin;
      rst_prev_reg <= reset_pin_n;
    end
  end

  // edge select 1 picks rising, 0 falling; a reset setup edge counts too
  assign nmi_event = nmi_edge_select ? (nmi_pin & ~nmi_prev_reg)
                                     : (~nmi_pin & nmi_prev_reg);
  assign reset_fall = rst_prev_reg & ~reset_pin_n;
  assign reset_is_por = nmi_pin;

endmodule

// >>> hdl/pdm_ram_decode.sv
// on-chip ram select with area 7 shadow mirroring
`timescale 1ns/1ps
module pdm_ram_decode #(
  parameter int RAM_KBYTES = pdm_pkg::PDM_RAM_KBYTES
) (
  input wire logic [27:0] bus_addr,
  output logic ram_sel,
  output logic ram_top_hit,
  output logic [$clog2(RAM_KBYTES*1024)-1:0] ram_offset
);
  import pdm_pkg::*;
  localparam int OFS_W = $clog2(RAM_KBYTES * 1024);
  localparam logic [27:0] RAM_BASE = (RAM_KBYTES == 8) ? PDM_RAM8K_BASE : PDM_RAM4K_BASE;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign ram_top_hit = (bus_addr >= RAM_BASE);
  // every ram-sized window of area 7 folds onto the same cells
  assign ram_sel = (bus_addr[27:24] == PDM_AREA7_TAG);
  assign ram_offset = bus_addr[OFS_W-1:0];

endmodule

// >>> tb/pdm_monitor.sv
// port assertions for the power-down mode controller
`timescale 1ns/1ps
module pdm_monitor #(
  parameter int RAM_KBYTES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pdm_pkg::pdm_wake_t wake_in,
  input wire logic watchdog_overflow,
  input wire logic nmi_pin,
  input wire logic reset_pin_n,
  input wire pdm_pkg::pdm_clk_t clk_ctrl,
  input wire pdm_pkg::pdm_exit_t exit_evt,
  input wire pdm_pkg::pdm_state_t mode,
  input wire logic port_hold,
  input wire logic port_float,
  input wire logic [27:0] mem_addr,
  input wire logic ram_sel,
  input wire logic ram_top_hit
);
  import pdm_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // quiet: no pin event this cycle; false just after reset, so it only ever narrows checks
  logic nmi_q;
  logic rst_q;
  logic quiet;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_q <= 1'h0;
      rst_q <= 1'h0;
    end else begin
      nmi_q <= nmi_pin;
      rst_q <= reset_pin_n;
    end
  end
  assign quiet = (nmi_pin == nmi_q) && reset_pin_n && rst_q;
  sleep_clocks_a: assert property (
    mode == PDM_SLEEP |-> !clk_ctrl.cpu_run && clk_ctrl.sys_clk_run && clk_ctrl.periph_clk_run)
    else $error("clocks wrong in light sleep");
  stby_clocks_a: assert property (
    mode == PDM_STBY |-> clk_ctrl == 4'h0 && port_hold != port_float)
    else $error("clocks or ports wrong in deep standby");
  osc_wdt_only_a: assert property (mode == PDM_OSC_WAIT |-> clk_ctrl == 4'h1)
    else $error("more than the watchdog clocked while settling");
  osc_release_a: assert property (
    mode == PDM_OSC_WAIT && watchdog_overflow && quiet |=> mode == PDM_RUN && exit_evt == 5'h04)
    else $error("overflow did not restart the chip");
  irq_mask_a: assert property (mode == PDM_SLEEP && quiet && !wake_in.dma_addr_err &&
    (wake_in.irq_level <= wake_in.cpu_mask || !wake_in.irq_periph_en) |=> $stable(mode))
    else $error("refused interrupt ended sleep");
  irq_wake_a: assert property (mode == PDM_SLEEP && quiet && wake_in.irq_req &&
    wake_in.irq_periph_en && wake_in.irq_level > wake_in.cpu_mask |=> mode == PDM_RUN && exit_evt.irq)
    else $error("accepted interrupt did not end sleep");
  dma_wake_a: assert property (
    mode == PDM_SLEEP && quiet && wake_in.dma_addr_err && !wake_in.irq_req |=> exit_evt == 5'h08)
    else $error("dma address error did not end sleep");
  stby_stay_a: assert property (mode == PDM_STBY && quiet |=> mode == PDM_STBY)
    else $error("deep standby left without nmi or reset");
  por_exit_a: assert property ($fell(reset_pin_n) && nmi_pin |=> ##[0:1] exit_evt == 5'h02)
    else $error("power-on reset not taken");
  manual_exit_a: assert property ($fell(reset_pin_n) && !nmi_pin |=> ##[0:1] exit_evt == 5'h01)
    else $error("manual reset not taken");
  ram_map_a: assert property (ram_sel == (mem_addr[27:24] == 4'hf) && ram_top_hit ==
    (mem_addr >= ((RAM_KBYTES == 8) ? PDM_RAM8K_BASE : PDM_RAM4K_BASE)))
    else $error("ram decode wrong");
  stby_c: cover property (mode == PDM_STBY);
  nmi_c: cover property (exit_evt.nmi);
  manual_c: cover property (exit_evt.manual_reset);
endmodule

// >>> tb/pdm_wdt_model.sv
// watchdog stand-in: overflows after a preset count of watchdog-only clocks
`timescale 1ns/1ps
module pdm_wdt_model #(
  parameter int OVF_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pdm_pkg::pdm_clk_t clk_ctrl,
  output logic watchdog_overflow
);
  import pdm_pkg::*;
  int count_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 0;
      watchdog_overflow <= 1'h0;
    end else if (clk_ctrl == 4'h1) begin
      count_reg <= count_reg + 1;
      watchdog_overflow <= (count_reg == OVF_CYCLES - 1);
    end else begin
      count_reg <= 0;
      watchdog_overflow <= 1'h0;
    end
  end
endmodule

// >>> tb/test_power_down_mode_control.sv
// self-checking bench for the power-down mode controller
`timescale 1ns/1ps
module test_power_down_mode_control;
  import pdm_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [27:0] paddr = 28'h0;
  logic [31:0] pwdata = 32'h0;
  logic halt_exec = 1'h0;
  pdm_wake_t wake_in = '0;
  logic watchdog_run_enable = 1'h1;
  logic nmi_edge_select = 1'h1;
  logic nmi_pin = 1'h0;
  logic reset_pin_n = 1'h1;
  logic [27:0] mem_addr = 28'h0;
  logic [31:0] prdata;
  logic pready, pslverr, watchdog_overflow, port_hold, port_float, ram_sel, ram_top_hit, err;
  logic [12:0] ram_offset;
  logic [31:0] rd;
  pdm_clk_t clk_ctrl;
  pdm_exit_t exit_evt;
  pdm_state_t mode;
  int n_errors = 0;
  int checked = 0;
  localparam logic [27:0] A = PDM_STBY_CTRL_ADDR;

  always #10 pclk = ~pclk;

  pdm_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halt_exec, .wake_in, .watchdog_run_enable, .watchdog_overflow, .nmi_edge_select, .nmi_pin,
    .reset_pin_n, .clk_ctrl, .exit_evt, .mode, .port_hold, .port_float, .mem_addr, .ram_sel,
    .ram_top_hit, .ram_offset);
  pdm_wdt_model wdt (.pclk, .presetn, .clk_ctrl, .watchdog_overflow);

  // ----
  // shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [27:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      results();
    end
    check("pready", pready, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic halt();
    @(posedge pclk);
    halt_exec <= 1'h1;
    @(posedge pclk);
    halt_exec <= 1'h0;
    #1;
  endtask

  task automatic stays(input pdm_state_t m);
    repeat (3) @(posedge pclk);
    #1;
    check("mode held", mode, m);
    check("no exit", exit_evt, 32'h0);
    @(posedge pclk);
  endtask

  // bounded wait: the overflow count of the watchdog fits well inside it
  task automatic expect_exit(input logic [4:0] ev);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (exit_evt === 5'h0 && n < 40);
    if (n >= 40) begin
      n_errors++;
      results();
    end
    check("exit", exit_evt, ev);
    check("mode", mode, PDM_RUN);
    @(posedge pclk);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs();
    apb(1'h0, A, 32'h0);
    check("reset value", rd, 32'h1f);
    apb(1'h1, A, 32'hff);
    apb(1'h0, A, 32'h0);
    check("locked bits", rd, 32'h1f);
    apb(1'h0, 28'h5ffffb8, 32'h0);
    check("unmapped", err, 32'h1);
    @(posedge pclk);
    watchdog_run_enable <= 1'h0;
    apb(1'h1, A, 32'hc0);
    apb(1'h0, A, 32'h0);
    check("open bits", rd, 32'hdf);
    apb(1'h1, A, 32'h0);
  endtask

  task automatic t_sleep();
    halt();
    check("sleep", mode, PDM_SLEEP);
    check("sleep clk", clk_ctrl[3:1], 32'h3);
    wake_in <= '{1'h1, 4'h5, 4'h5, 1'h1, 1'h0};
    stays(PDM_SLEEP);
    wake_in <= '{1'h1, 4'h6, 4'h5, 1'h0, 1'h0};
    stays(PDM_SLEEP);
    wake_in.irq_periph_en <= 1'h1;
    expect_exit(5'h10);
    wake_in <= '0;
    halt();
    @(posedge pclk);
    wake_in.dma_addr_err <= 1'h1;
    expect_exit(5'h08);
    wake_in <= '0;
    halt();
    @(posedge pclk);
    nmi_pin <= 1'h1;
    expect_exit(5'h04);
  endtask

  task automatic t_stby();
    apb(1'h1, A, 32'hc0);
    halt();
    check("stby", mode, PDM_STBY);
    check("stby clk", clk_ctrl, 32'h0);
    check("float", {port_hold, port_float}, 32'h1);
    wake_in <= '{1'h1, 4'hf, 4'h0, 1'h1, 1'h1};
    stays(PDM_STBY);
    wake_in <= '0;
    nmi_edge_select <= 1'h0;
    nmi_pin <= 1'h0;
    expect_exit(5'h04);
    apb(1'h1, A, 32'h80);
    halt();
    check("hold", {port_hold, port_float}, 32'h2);
    nmi_pin <= 1'h1;
    stays(PDM_STBY);
    reset_pin_n <= 1'h0;
    expect_exit(5'h02);
    reset_pin_n <= 1'h1;
    apb(1'h0, A, 32'h0);
    check("after reset", rd, 32'h1f);
    halt();
    @(posedge pclk);
    nmi_edge_select <= 1'h1;
    nmi_pin <= 1'h0;
    stays(PDM_SLEEP);
    reset_pin_n <= 1'h0;
    expect_exit(5'h01);
    reset_pin_n <= 1'h1;
  endtask

  task automatic t_ram();
    logic [27:0] a [5];
    a = '{28'hfffe000, 28'hfffffff, 28'hf000000, 28'hf7ff123, 28'he123456};
    foreach (a[i]) begin
      @(posedge pclk);
      mem_addr <= a[i];
      #1;
      check("ram sel", ram_sel, 32'(a[i][27:24] == 4'hf));
      check("ram top", ram_top_hit, 32'(a[i] >= PDM_RAM8K_BASE));
      if (ram_sel === 1'h1) begin
        check("ram offset", ram_offset, 32'(a[i][12:0]));
      end
    end
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_sleep();
    t_stby();
    t_ram();
    results();
  end
endmodule

bind pdm_ctrl pdm_monitor #(.RAM_KBYTES(RAM_KBYTES)) mon (.pclk, .presetn, .wake_in, .watchdog_overflow,
  .nmi_pin, .reset_pin_n, .clk_ctrl, .exit_evt, .mode, .port_hold, .port_float, .mem_addr, .ram_sel,
  .ram_top_hit);
